// file: src/spfc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a fill level.
  Assumes DEPTH is a power of two and a reset already synchronised to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [AW:0] level_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Status and handshakes
  assign level_o = wr_ptr - rd_ptr;
  assign in_ready_o = level_o != (AW + 1)'(DEPTH);
  assign out_valid_o = level_o != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers, flush empties the buffer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW + 1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW + 1)'(1);
      end
    end
  end
endmodule : spfc_fifo
`default_nettype wire

// file: src/spfc_pkg.sv
/*
  Constants, encodings and helpers for the serial host port with flow control.
  Assumes a single 200 MHz clock and a byte-addressed Avalon-MM register slave.
*/
// Behaviour
// - Only one of the parallel bus and the serial port is active at a time, the parallel bus after reset.
// - The bit rate is one of eight rates from 1200 to 115200 baud, 57600 after reset.
// - No parity carries eight data bits, even or odd parity carries seven data bits.
// - After reset the format is no parity with eight data bits.
// - Interface, rate, parity and flow settings survive a preset of the port.
// - Five flow methods exist: none, in-band characters, DTR/DSR, RTS/CTS and modem, in-band after reset.
// - In in-band mode transmission stops on an XOFF code 13h and resumes on an XON code 11h.
// - In DTR/DSR mode a character is started only while DSR is asserted.
// - In DTR/DSR mode DTR drops while about 100 received characters wait, and returns when space frees.
// - In RTS/CTS mode a character is started only while CTS is asserted.
// - In RTS/CTS and modem modes RTS drops while about 100 received characters wait, and returns after.
// - In modem mode DTR is asserted while the serial port is selected, and both DSR and CTS gate sending.
package spfc_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ_NOM = 1000000000 / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_TXDATA = 5'h08;
  localparam logic [4:0] REG_RXDATA = 5'h0c;
  localparam logic [4:0] REG_CONTROL = 5'h10;

  // Field positions
  localparam int CFG_SERIAL = 0;
  localparam int CFG_BAUD_LSB = 4;
  localparam int CFG_PAR_LSB = 8;
  localparam int CFG_FLOW_LSB = 12;
  localparam int ST_TX_FULL = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_VALID = 2;
  localparam int ST_XOFF = 3;
  localparam int ST_NEAR_FULL = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_RX_LEVEL_LSB = 8;
  localparam int RX_VALID_BIT = 8;
  localparam int CTRL_PRESET = 0;

  // Modes
  typedef enum logic [1:0] {SPFC_PAR_NONE, SPFC_PAR_EVEN, SPFC_PAR_ODD} spfc_par_t;
  typedef enum logic [2:0] {SPFC_FLOW_NONE, SPFC_FLOW_XON, SPFC_FLOW_DTRDSR, SPFC_FLOW_RTSCTS,
                            SPFC_FLOW_MODEM} spfc_flow_t;
  typedef enum logic {SPFC_TX_IDLE, SPFC_TX_SHIFT} spfc_tx_state_t;
  typedef enum logic [1:0] {SPFC_RX_IDLE, SPFC_RX_START, SPFC_RX_DATA, SPFC_RX_STOP} spfc_rx_state_t;

  // Reset values
  localparam logic [2:0] BAUD_DEFAULT = 3'h6;

  // Characters and buffers
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [2:0] RX_LAST_SLOT = 3'h7;
  localparam int TX_DEPTH = 32;
  localparam int RX_DEPTH = 128;
  localparam logic [7:0] RX_NEAR_FULL = 8'h64;

  // Bit rate for each selector value
  function automatic int spfc_baud(input logic [2:0] sel);
    case (sel)
      3'h0: return 1200;
      3'h1: return 2400;
      3'h2: return 4800;
      3'h3: return 9600;
      3'h4: return 19200;
      3'h5: return 38400;
      3'h6: return 57600;
      default: return 115200;
    endcase
  endfunction : spfc_baud

  // Parity bit over seven data bits
  function automatic logic spfc_par_bit(input logic [6:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : spfc_par_bit
endpackage : spfc_pkg

// file: src/spfc_top.sv
/*
  Serial host port: UART with selectable rate, parity and five flow methods,
  register access over Avalon-MM. Assumes modem lines already at logic level.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_top #(
  parameter int CLK_HZ = spfc_pkg::CLK_HZ_NOM
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Serial line
  output logic TXD_O,
  input wire logic RXD_I,
  output logic DTR_O,
  input wire logic DSR_I,
  output logic RTS_O,
  input wire logic CTS_I,
  // Interface selection
  output logic SERIAL_ACTIVE_O,
  output logic PARALLEL_ACTIVE_O
);
  logic rst_meta;
  logic rst_n;
  logic cfg_serial;
  logic [2:0] cfg_baud;
  logic [1:0] cfg_par;
  logic [2:0] cfg_flow;
  logic par_on;
  logic par_odd;
  logic [17:0] div_tab [8];
  logic [17:0] bit_div;
  logic wr_en;
  logic rd_ack;
  logic rx_pop;
  logic preset;
  logic [31:0] rd_value;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [7:0] tx_out_data;
  logic tx_ok;
  logic tx_pop;
  spfc_pkg::spfc_tx_state_t tx_state;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic [17:0] tx_tmr;
  spfc_pkg::spfc_rx_state_t rx_state;
  logic [17:0] rx_tmr;
  logic [2:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_done;
  logic [7:0] rx_char;
  logic rx_ferr;
  logic rx_perr;
  logic rx_ctl;
  logic rx_push;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [7:0] rx_out_data;
  logic [7:0] rx_level;
  logic near_full;
  logic xoff_held;
  logic overrun;
  logic frame_err;
  logic par_err;
  logic st_clr;
  logic next_dtr;
  logic next_rts;

  // Reset release through two flip-flops
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n <= rst_meta;
    end
  end

  // Bit period in clocks for each rate selector
  for (genvar g = 0; g < 8; g++) begin : g_div
    assign div_tab[g] = 18'(CLK_HZ / spfc_pkg::spfc_baud(3'(g)));
  end
  assign bit_div = div_tab[cfg_baud];
  assign par_on = cfg_par == spfc_pkg::SPFC_PAR_EVEN || cfg_par == spfc_pkg::SPFC_PAR_ODD;
  assign par_odd = cfg_par == spfc_pkg::SPFC_PAR_ODD;

  // Bus handshake: full TX buffer stalls writes to REG_TXDATA, reads take one wait cycle
  assign AVS_WAITREQUEST_O = (AVS_WRITE_I && AVS_ADDRESS_I == spfc_pkg::REG_TXDATA && !tx_in_ready)
                           || (AVS_READ_I && !rd_ack);
  assign wr_en = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign preset = wr_en && AVS_ADDRESS_I == spfc_pkg::REG_CONTROL && AVS_WRITEDATA_I[spfc_pkg::CTRL_PRESET];
  assign st_clr = wr_en && AVS_ADDRESS_I == spfc_pkg::REG_STATUS;
  assign rx_pop = AVS_READ_I && !rd_ack && AVS_ADDRESS_I == spfc_pkg::REG_RXDATA;

  // Settings, kept across a preset
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_serial <= 1'h0;
      cfg_baud <= spfc_pkg::BAUD_DEFAULT;
      cfg_par <= spfc_pkg::SPFC_PAR_NONE;
      cfg_flow <= spfc_pkg::SPFC_FLOW_XON;
    end else if (wr_en && AVS_ADDRESS_I == spfc_pkg::REG_CONFIG) begin
      cfg_serial <= AVS_WRITEDATA_I[spfc_pkg::CFG_SERIAL];
      cfg_baud <= AVS_WRITEDATA_I[spfc_pkg::CFG_BAUD_LSB +: 3];
      cfg_par <= AVS_WRITEDATA_I[spfc_pkg::CFG_PAR_LSB +: 2];
      cfg_flow <= AVS_WRITEDATA_I[spfc_pkg::CFG_FLOW_LSB +: 3];
    end
  end

  // Read mux
  always_comb begin
    rd_value = '0;
    if (AVS_ADDRESS_I == spfc_pkg::REG_CONFIG) begin
      rd_value[spfc_pkg::CFG_SERIAL] = cfg_serial;
      rd_value[spfc_pkg::CFG_BAUD_LSB +: 3] = cfg_baud;
      rd_value[spfc_pkg::CFG_PAR_LSB +: 2] = cfg_par;
      rd_value[spfc_pkg::CFG_FLOW_LSB +: 3] = cfg_flow;
    end else if (AVS_ADDRESS_I == spfc_pkg::REG_STATUS) begin
      rd_value[spfc_pkg::ST_TX_FULL] = !tx_in_ready;
      rd_value[spfc_pkg::ST_TX_EMPTY] = !tx_out_valid;
      rd_value[spfc_pkg::ST_RX_VALID] = rx_out_valid;
      rd_value[spfc_pkg::ST_XOFF] = xoff_held;
      rd_value[spfc_pkg::ST_NEAR_FULL] = near_full;
      rd_value[spfc_pkg::ST_OVERRUN] = overrun;
      rd_value[spfc_pkg::ST_FRAME] = frame_err;
      rd_value[spfc_pkg::ST_PARITY] = par_err;
      rd_value[spfc_pkg::ST_RX_LEVEL_LSB +: 8] = rx_level;
    end else if (AVS_ADDRESS_I == spfc_pkg::REG_RXDATA) begin
      rd_value[7:0] = rx_out_data;
      rd_value[spfc_pkg::RX_VALID_BIT] = rx_out_valid;
    end
  end

  // Read data register and wait-cycle flag
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack <= 1'h0;
      AVS_READDATA_O <= '0;
    end else begin
      rd_ack <= AVS_READ_I && !rd_ack;
      if (AVS_READ_I && !rd_ack) begin
        AVS_READDATA_O <= rd_value;
      end
    end
  end

  // Transmit buffer
  spfc_fifo #(.WIDTH(8), .DEPTH(spfc_pkg::TX_DEPTH)) u_tx_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .flush_i(preset),
    .in_valid_i(AVS_WRITE_I && AVS_ADDRESS_I == spfc_pkg::REG_TXDATA),
    .in_ready_o(tx_in_ready),
    .in_data_i(AVS_WRITEDATA_I[7:0]),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_pop),
    .out_data_o(tx_out_data),
    .level_o()
  );

  // Permission to start the next character
  always_comb begin
    case (cfg_flow)
      spfc_pkg::SPFC_FLOW_XON: tx_ok = !xoff_held;
      spfc_pkg::SPFC_FLOW_DTRDSR: tx_ok = DSR_I;
      spfc_pkg::SPFC_FLOW_RTSCTS: tx_ok = CTS_I;
      spfc_pkg::SPFC_FLOW_MODEM: tx_ok = DSR_I && CTS_I;
      default: tx_ok = 1'h1;
    endcase
  end
  assign tx_pop = tx_state == spfc_pkg::SPFC_TX_IDLE && cfg_serial && tx_ok && tx_out_valid;

  // Transmitter: start, data LSB first, optional parity, stop
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= spfc_pkg::SPFC_TX_IDLE;
      tx_sh <= '1;
      tx_bits <= '0;
      tx_tmr <= '0;
    end else begin
      case (tx_state)
        spfc_pkg::SPFC_TX_IDLE: begin
          if (tx_pop) begin
            if (par_on) begin
              tx_sh <= {1'h1, spfc_pkg::spfc_par_bit(tx_out_data[6:0], par_odd), tx_out_data[6:0], 1'h0};
            end else begin
              tx_sh <= {1'h1, tx_out_data, 1'h0};
            end
            tx_bits <= spfc_pkg::TX_LAST_BIT;
            tx_tmr <= '0;
            tx_state <= spfc_pkg::SPFC_TX_SHIFT;
          end
        end
        default: begin
          if (tx_tmr >= bit_div - 18'h1) begin
            tx_tmr <= '0;
            tx_sh <= {1'h1, tx_sh[9:1]};
            if (tx_bits == '0) begin
              tx_state <= spfc_pkg::SPFC_TX_IDLE;
            end else begin
              tx_bits <= tx_bits - 4'h1;
            end
          end else begin
            tx_tmr <= tx_tmr + 18'h1;
          end
        end
      endcase
    end
  end
  assign TXD_O = tx_sh[0];

  // Receiver: mid-bit sampling, eight slots then stop
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= spfc_pkg::SPFC_RX_IDLE;
      rx_tmr <= '0;
      rx_cnt <= '0;
      rx_sh <= '0;
      rx_done <= 1'h0;
      rx_char <= '0;
      rx_ferr <= 1'h0;
      rx_perr <= 1'h0;
    end else begin
      rx_done <= 1'h0;
      case (rx_state)
        spfc_pkg::SPFC_RX_IDLE: begin
          rx_tmr <= '0;
          if (cfg_serial && !RXD_I) begin
            rx_state <= spfc_pkg::SPFC_RX_START;
          end
        end
        spfc_pkg::SPFC_RX_START: begin
          if (rx_tmr >= (bit_div >> 1)) begin
            rx_tmr <= '0;
            rx_cnt <= '0;
            rx_state <= RXD_I ? spfc_pkg::SPFC_RX_IDLE : spfc_pkg::SPFC_RX_DATA;
          end else begin
            rx_tmr <= rx_tmr + 18'h1;
          end
        end
        spfc_pkg::SPFC_RX_DATA: begin
          if (rx_tmr >= bit_div - 18'h1) begin
            rx_tmr <= '0;
            rx_sh <= {RXD_I, rx_sh[7:1]};
            if (rx_cnt == spfc_pkg::RX_LAST_SLOT) begin
              rx_state <= spfc_pkg::SPFC_RX_STOP;
            end else begin
              rx_cnt <= rx_cnt + 3'h1;
            end
          end else begin
            rx_tmr <= rx_tmr + 18'h1;
          end
        end
        default: begin
          if (rx_tmr >= bit_div - 18'h1) begin
            rx_state <= spfc_pkg::SPFC_RX_IDLE;
            rx_done <= 1'h1;
            rx_ferr <= !RXD_I;
            rx_char <= par_on ? {1'h0, rx_sh[6:0]} : rx_sh;
            rx_perr <= par_on && rx_sh[7] != spfc_pkg::spfc_par_bit(rx_sh[6:0], par_odd);
          end else begin
            rx_tmr <= rx_tmr + 18'h1;
          end
        end
      endcase
    end
  end

  // In-band flow codes are consumed, not buffered
  assign rx_ctl = cfg_flow == spfc_pkg::SPFC_FLOW_XON
                && (rx_char == spfc_pkg::XOFF_CHAR || rx_char == spfc_pkg::XON_CHAR);
  assign rx_push = rx_done && !rx_ctl;

  // Receive buffer
  spfc_fifo #(.WIDTH(8), .DEPTH(spfc_pkg::RX_DEPTH)) u_rx_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .flush_i(preset),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(rx_char),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_out_data),
    .level_o(rx_level)
  );
  assign near_full = rx_level >= spfc_pkg::RX_NEAR_FULL;

  // XOFF/XON state
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      xoff_held <= 1'h0;
    end else if (rx_done && rx_ctl) begin
      xoff_held <= rx_char == spfc_pkg::XOFF_CHAR;
    end else if (preset || cfg_flow != spfc_pkg::SPFC_FLOW_XON) begin
      xoff_held <= 1'h0;
    end
  end

  // Sticky errors, a new event beats a clear
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'h0;
      frame_err <= 1'h0;
      par_err <= 1'h0;
    end else begin
      if (rx_push && !rx_in_ready) begin
        overrun <= 1'h1;
      end else if (st_clr && AVS_WRITEDATA_I[spfc_pkg::ST_OVERRUN]) begin
        overrun <= 1'h0;
      end
      if (rx_done && rx_ferr) begin
        frame_err <= 1'h1;
      end else if (st_clr && AVS_WRITEDATA_I[spfc_pkg::ST_FRAME]) begin
        frame_err <= 1'h0;
      end
      if (rx_done && rx_perr) begin
        par_err <= 1'h1;
      end else if (st_clr && AVS_WRITEDATA_I[spfc_pkg::ST_PARITY]) begin
        par_err <= 1'h0;
      end
    end
  end

  // Handshake line values
  always_comb begin
    next_dtr = cfg_serial;
    next_rts = cfg_serial;
    if (cfg_flow == spfc_pkg::SPFC_FLOW_DTRDSR) begin
      next_dtr = cfg_serial && !near_full;
    end
    if (cfg_flow == spfc_pkg::SPFC_FLOW_RTSCTS || cfg_flow == spfc_pkg::SPFC_FLOW_MODEM) begin
      next_rts = cfg_serial && !near_full;
    end
  end

  // Handshake and selection outputs
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      DTR_O <= 1'h0;
      RTS_O <= 1'h0;
    end else begin
      DTR_O <= next_dtr;
      RTS_O <= next_rts;
    end
  end
  assign SERIAL_ACTIVE_O = cfg_serial;
  assign PARALLEL_ACTIVE_O = !cfg_serial;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!rst_n);

  a_iface_exclusive: assert property ((SERIAL_ACTIVE_O != PARALLEL_ACTIVE_O)
      and (PARALLEL_ACTIVE_O |=> !DTR_O && !RTS_O))
    else $error("both interfaces active or lines driven");
  a_bit_timer: assert property (tx_state == spfc_pkg::SPFC_TX_SHIFT |-> tx_tmr < bit_div)
    else $error("tx bit timer past period");
  a_parity_bit: assert property (tx_pop && par_on |=>
      tx_sh[8] == spfc_pkg::spfc_par_bit($past(tx_out_data[6:0]), $past(par_odd)) && !tx_sh[0])
    else $error("wrong parity bit");
  a_reset_defaults: assert property ($rose(rst_n) |-> !cfg_serial && cfg_par == 2'h0
      && cfg_baud == spfc_pkg::BAUD_DEFAULT && cfg_flow == spfc_pkg::SPFC_FLOW_XON)
    else $error("wrong defaults");
  a_preset_keeps: assert property (preset |=> $stable(cfg_baud) && $stable(cfg_par)
      && $stable(cfg_flow) && $stable(cfg_serial))
    else $error("preset changed settings");
  a_xoff_stops: assert property (rx_done && rx_ctl && rx_char == spfc_pkg::XOFF_CHAR
      |=> xoff_held && !tx_pop)
    else $error("sent after xoff");
  a_dsr_gate: assert property (tx_pop && cfg_flow == spfc_pkg::SPFC_FLOW_DTRDSR |-> DSR_I)
    else $error("sent without dsr");
  a_dtr_near_full: assert property (cfg_flow == spfc_pkg::SPFC_FLOW_DTRDSR && near_full
      && $stable(cfg_flow) |=> !DTR_O)
    else $error("dtr high while near full");
  a_cts_gate: assert property (tx_pop && cfg_flow == spfc_pkg::SPFC_FLOW_RTSCTS |-> CTS_I)
    else $error("sent without cts");
  a_rts_near_full: assert property (cfg_flow == spfc_pkg::SPFC_FLOW_MODEM && near_full
      && $stable(cfg_flow) |=> !RTS_O)
    else $error("rts high while near full");
  a_modem_dtr: assert property (cfg_flow == spfc_pkg::SPFC_FLOW_MODEM && cfg_serial
      && $stable(cfg_flow) && $stable(cfg_serial) |=> DTR_O)
    else $error("modem dtr low");
  a_start_bit: assert property (tx_pop |=> !TXD_O ##1 (!TXD_O)[*1])
    else $error("start bit not low");
  a_stop_bit: assert property (tx_state == spfc_pkg::SPFC_TX_SHIFT && tx_bits == 4'h0 |-> TXD_O)
    else $error("stop bit not high");
endmodule : spfc_top
`default_nettype wire

// file: verification/spfc_host_model.sv
/*
  Host on the far side of the serial line: sends characters into the port
  and collects what the port transmits. Assumes idle-high logic-level lines.
*/
`timescale 1ns/1ps
`default_nettype none
module spfc_host_model (
  // Clock
  input wire logic clk_i,
  // Serial line
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] rx_q[$];
  logic [7:0] c;
  int bit_clks = 10;
  int len;
  int frame_errs = 0;

  initial rxd_o = 1'b1;

  // Start, eight bits LSB first, stop; host keeps traffic paced
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] f;
    f = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (bit_clks - 1) @(posedge clk_i);
    end
  endtask : send_char

  // Receiver; bit period taken from start bit, so first data bit must be 1
  initial begin
    forever begin
      @(negedge clk_i);
      if (!txd_i) begin
        len = 0;
        while (!txd_i) begin
          len++;
          @(negedge clk_i);
        end
        repeat (len / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
          c[i] = txd_i;
          repeat (len) @(negedge clk_i);
        end
        if (!txd_i) begin
          frame_errs++;
        end
        rx_q.push_back(c);
      end
    end
  end
endmodule : spfc_host_model
`default_nettype wire

// file: verification/tb_spfc_top.sv
/*
  Testbench for the serial host port: register accesses over Avalon-MM.
  Assumes spfc_top and the host model; handshake lines driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_spfc_top;
  localparam int CLK_HZ = 1152000;
  logic clk, rst_n, rd, wr, dsr, cts, wait_req, txd, rxd, dtr, rts, ser, par;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, q;
  int fails = 0;
  int compares = 0;
  int rates[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};

  spfc_top #(.CLK_HZ(CLK_HZ)) dut_u (.MCLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_req), .TXD_O(txd), .RXD_I(rxd), .DTR_O(dtr), .DSR_I(dsr),
    .RTS_O(rts), .CTS_I(cts), .SERIAL_ACTIVE_O(ser), .PARALLEL_ACTIVE_O(par));
  spfc_host_model host_u (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // One access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_rd, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= is_rd;
    wr <= !is_rd;
    wdata <= d;
    @(posedge clk);
    while (wait_req) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Return off the edge so registered outputs are settled for checks
    @(negedge clk);
  endtask : bus

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b1, a, 32'h0);
    chk(what, exp, q);
  endtask : rchk

  // Next character seen by the host, bounded wait
  task automatic tx_chk(input logic [7:0] exp);
    int n = 0;
    while (host_u.rx_q.size() == 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("tx char", {24'h0, exp}, host_u.rx_q.size() > 0 ? {24'h0, host_u.rx_q.pop_front()} : 32'hx);
  endtask : tx_chk

  // Nothing may reach the host meanwhile
  task automatic quiet;
    repeat (300) @(posedge clk);
    chk("tx idle", 32'h0, host_u.rx_q.size());
  endtask : quiet

  task automatic finish_test;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test();
  end

  // Test sequence
  initial begin
    {rst_n, rd, wr, dsr, cts, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(5'h00, 32'h00001060, "config");
    rchk(5'h14, 32'h0, "unmapped");
    chk("parallel", 32'h1, {31'h0, par & !ser});
    bus(1'b0, 5'h00, 32'h71);
    chk("serial", 32'h1, {31'h0, ser & !par});
    bus(1'b0, 5'h08, 32'ha5);
    tx_chk(8'ha5);
    $display("Defaults test done");
    // In-band flow
    bus(1'b0, 5'h00, 32'h1071);
    host_u.send_char(8'h13);
    repeat (5) @(posedge clk);
    rchk(5'h04, 32'h0a, "status xoff");
    bus(1'b0, 5'h08, 32'h55);
    quiet();
    host_u.send_char(8'h11);
    tx_chk(8'h55);
    rchk(5'h04, 32'h02, "status xon");
    $display("In-band test done");
    // DSR gate and DTR on a nearly full receive buffer
    bus(1'b0, 5'h00, 32'h2071);
    chk("dtr", 32'h1, {31'h0, dtr});
    bus(1'b0, 5'h08, 32'h33);
    quiet();
    dsr <= 1'b1;
    tx_chk(8'h33);
    for (int i = 0; i < 100; i++) host_u.send_char(i[7:0]);
    repeat (5) @(posedge clk);
    chk("dtr full", 32'h0, {31'h0, dtr});
    rchk(5'h04, 32'h6416, "status near full");
    rchk(5'h0c, 32'h100, "rx char");
    repeat (3) @(posedge clk);
    chk("dtr space", 32'h1, {31'h0, dtr});
    $display("DTR/DSR test done");
    // CTS gate with a full transmit buffer
    bus(1'b0, 5'h00, 32'h3071);
    chk("rts", 32'h1, {31'h0, rts});
    for (int i = 0; i < 32; i++) bus(1'b0, 5'h08, 32'(2 * i + 1));
    rchk(5'h04, 32'h6305, "status tx full");
    quiet();
    cts <= 1'b1;
    for (int i = 0; i < 32; i++) tx_chk(8'(2 * i + 1));
    host_u.send_char(8'h99);
    repeat (5) @(posedge clk);
    chk("rts full", 32'h0, {31'h0, rts});
    $display("RTS/CTS test done");
    // Modem mode
    bus(1'b0, 5'h00, 32'h4071);
    chk("rts modem", 32'h0, {31'h0, rts});
    chk("dtr modem", 32'h1, {31'h0, dtr});
    dsr <= 1'b0;
    bus(1'b0, 5'h08, 32'h37);
    quiet();
    dsr <= 1'b1;
    tx_chk(8'h37);
    // Preset keeps settings
    bus(1'b0, 5'h10, 32'h1);
    rchk(5'h00, 32'h4071, "config kept");
    rchk(5'h0c, 32'h0, "rx flushed");
    chk("rts preset", 32'h1, {31'h0, rts});
    $display("Modem test done");
    // Every bit rate
    for (int s = 0; s < 8; s++) begin
      bus(1'b0, 5'h00, 32'h01 | (s << 4));
      bus(1'b0, 5'h08, 32'h01);
      tx_chk(8'h01);
      chk("bit period", CLK_HZ / rates[s], host_u.len);
      // Let the stop bit end before the rate changes
      repeat (CLK_HZ / rates[s]) @(posedge clk);
    end
    // Seven bits with parity
    bus(1'b0, 5'h00, 32'h171);
    bus(1'b0, 5'h08, 32'h43);
    tx_chk(8'hc3);
    // Receive a seven bit character with wrong even parity, then clear the flag
    host_u.send_char(8'h43);
    repeat (5) @(posedge clk);
    rchk(5'h04, 32'h186, "status parity");
    bus(1'b0, 5'h04, 32'h80);
    rchk(5'h04, 32'h106, "parity cleared");
    rchk(5'h0c, 32'h143, "rx parity char");
    bus(1'b0, 5'h00, 32'h271);
    bus(1'b0, 5'h08, 32'hc3);
    tx_chk(8'h43);
    bus(1'b0, 5'h00, 32'h0);
    chk("parallel back", 32'h1, {31'h0, par & !ser});
    chk("stop bits", 32'h0, host_u.frame_errs);
    $display("Rate and parity test done");
    finish_test();
  end
endmodule : tb_spfc_top
`default_nettype wire
